/* File: rtl/bridge_pwm_pkg.sv */
// constants and carrier types of the bridge pwm stage
`default_nettype none
package bridge_pwm_pkg;
   // -----------------------------------------------------------
   // register byte offsets
   // -----------------------------------------------------------
   localparam logic [7:0] OFS_PERIOD   = 8'h00;
   localparam logic [7:0] OFS_DUTY     = 8'h04;
   localparam logic [7:0] OFS_MODE     = 8'h08;
   localparam logic [7:0] OFS_DEADBAND = 8'h0c;
   localparam logic [7:0] OFS_SHUTDOWN = 8'h10;
   localparam logic [7:0] OFS_PRESCALE = 8'h14;
   localparam logic [7:0] OFS_STATUS   = 8'h18;
   // -----------------------------------------------------------
   // reset values
   // -----------------------------------------------------------
   localparam logic [7:0] RST_PERIOD   = 8'hff;
   localparam logic [7:0] RST_BYTE     = 8'h00;
   localparam logic [1:0] RST_PRESCALE = 2'h0;
   // -----------------------------------------------------------
   // field positions and codes
   // -----------------------------------------------------------
   localparam int MODE_CFG_HI    = 7;
   localparam int MODE_DIR_BIT   = 7;
   localparam int MODE_DUTY_HI   = 5;
   localparam int MODE_POL_AC    = 1;
   localparam int MODE_POL_BD    = 0;
   localparam int SD_STATUS_BIT  = 7;
   localparam int SD_SRC_HI      = 6;
   localparam int STAT_FLAG_BIT  = 0;
   localparam logic [1:0] MODE_PWM     = 2'h3;
   localparam logic [1:0] CFG_SINGLE   = 2'h0;
   localparam logic [1:0] CFG_HALF     = 2'h2;
   localparam logic [3:0] OE_SINGLE    = 4'h1;
   localparam logic [3:0] OE_HALF      = 4'h3;
   localparam logic [3:0] OE_FULL      = 4'hf;
   // -----------------------------------------------------------
   // timing: one instruction cycle is four oscillator clocks
   // -----------------------------------------------------------
   localparam int         CLK_PERIOD_NS = 5;
   localparam int         TCY_NS        = 20;
   localparam int         TCY_CLKS      = TCY_NS / CLK_PERIOD_NS;
   localparam logic [3:0] PRE_MAX_1     = 4'h0;
   localparam logic [3:0] PRE_MAX_4     = 4'h3;
   localparam logic [3:0] PRE_MAX_16    = 4'hf;
   // -----------------------------------------------------------
   // carrier for the four bridge pins, index 0..3 = a..d
   // -----------------------------------------------------------
   typedef struct packed {
      logic [3:0] drive;
      logic [3:0] oe;
   } pins_type;
endpackage
`default_nettype wire

/* File: rtl/bridge_pwm.sv */
// enhanced bridge pwm stage with dead band and auto shutdown
// How it works
// - period is four clocks times (period_limit plus one) times prescale
// - pulse width is one clock times 10-bit duty times prescale
// - dead band lasts four clocks times the 7-bit deadband_count
// - half bridge drives pwm on a and its complement on b
// - half bridge delays each turn-on edge by the dead band
// - dead band longer than the pulse keeps that output inactive
// - full forward: a active, d modulated, b and c inactive
// - full reverse: c active, b modulated, a and d inactive
// - direction_select change takes effect from the next pwm cycle
// - direction change: b, d inactive first, swap a/c, resume next period
// - a and c swap one prescaled clock before period end
// - full bridge applies no dead band
// - mode_select low bits set polarity of pairs a/c and b/d
// - period_match_flag sets as the second pwm period begins
// - shutdown from fault_input low, comparator 1, 2, or firmware
// - outputs stay held in shutdown until the first period end after shutdown_status clears
// - shutdown sets shutdown_status until firmware clears it
// - shutdown forces enabled outputs at once, not at a boundary
// - each pair takes its own shutdown state: high, low or float
// - shutdown state 00 low, 01 high, 1x high impedance
// - source codes: 000 off, bit0 cmp1, bit1 cmp2, bit2 fault low
// - output_config 00 single, 01 fwd, 10 half, 11 reverse
// - mode_select 11xx is pwm; bit1 a/c low, bit0 b/d low
//
// Our own choices: the address map and the Wishbone slave port.
`default_nettype none
module bridge_pwm (
   input  wire logic                     clk_i,
   input  wire logic                     rst_i,
   input  wire logic                     ce_i,
   input  wire logic                     cyc_i,
   input  wire logic                     stb_i,
   input  wire logic                     we_i,
   input  wire logic [7:0]               adr_i,
   input  wire logic [3:0]               sel_i,
   input  wire logic [31:0]              dat_i,
   output logic      [31:0]              dat_o,
   output logic                          ack_o,
   input  wire logic                     fault_input_n_i,
   input  wire logic                     cmp1_i,
   input  wire logic                     cmp2_i,
   output bridge_pwm_pkg::pins_type      pins_o
);
   import bridge_pwm_pkg::*;

   // -----------------------------------------------------------
   // register bus
   // -----------------------------------------------------------
   logic [7:0]  period_limit_q;
   logic [7:0]  duty_high_byte_q;
   logic [7:0]  pwm_mode_control_q;
   logic [7:0]  deadband_control_q;
   logic [6:0]  shutdown_control_q;
   logic [1:0]  prescale_q;
   logic        shutdown_status_q;
   logic        period_match_flag_q;
   logic        ack_q;
   logic [31:0] dat_q;
   logic [31:0] rd_data;
   logic [7:0]  period_timer_q;

   wire logic req     = cyc_i & stb_i & ~ack_q;
   wire logic wr      = req & we_i & sel_i[0];
   wire logic wr_per  = wr & (adr_i == OFS_PERIOD);
   wire logic wr_duty = wr & (adr_i == OFS_DUTY);
   wire logic wr_mode = wr & (adr_i == OFS_MODE);
   wire logic wr_db   = wr & (adr_i == OFS_DEADBAND);
   wire logic wr_sd   = wr & (adr_i == OFS_SHUTDOWN);
   wire logic wr_pre  = wr & (adr_i == OFS_PRESCALE);
   wire logic wr_stat = wr & (adr_i == OFS_STATUS);

   always_comb begin
      case (adr_i)
         OFS_PERIOD:   rd_data = {24'h0, period_limit_q};
         OFS_DUTY:     rd_data = {24'h0, duty_high_byte_q};
         OFS_MODE:     rd_data = {24'h0, pwm_mode_control_q};
         OFS_DEADBAND: rd_data = {24'h0, deadband_control_q};
         OFS_SHUTDOWN:
            rd_data = {24'h0, shutdown_status_q, shutdown_control_q};
         OFS_PRESCALE: rd_data = {30'h0, prescale_q};
         OFS_STATUS:
            rd_data = {16'h0, period_timer_q, 7'h0,
                       period_match_flag_q};
         default:      rd_data = 32'h0;
      endcase
   end

   // unmapped addresses still ack, read zero and drop writes
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
         dat_q <= 32'h0;
      end else if (ce_i) begin
         ack_q <= req;
         dat_q <= req ? rd_data : dat_q;
      end
   end

   assign ack_o = ack_q;
   assign dat_o = dat_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         period_limit_q     <= RST_PERIOD;
         duty_high_byte_q   <= RST_BYTE;
         pwm_mode_control_q <= RST_BYTE;
         deadband_control_q <= RST_BYTE;
         shutdown_control_q <= RST_BYTE[6:0];
         prescale_q         <= RST_PRESCALE;
      end else if (ce_i) begin
         if (wr_per)  period_limit_q     <= dat_i[7:0];
         if (wr_duty) duty_high_byte_q   <= dat_i[7:0];
         if (wr_mode) pwm_mode_control_q <= dat_i[7:0];
         if (wr_db)   deadband_control_q <= dat_i[7:0];
         if (wr_sd)   shutdown_control_q <= dat_i[6:0];
         if (wr_pre)  prescale_q         <= dat_i[1:0];
      end
   end

   // -----------------------------------------------------------
   // pin synchronisers: bit 0 fault, 1 comparator 1, 2 comp. 2
   // -----------------------------------------------------------
   logic [2:0] meta_q;
   logic [2:0] pin_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta_q <= 3'h1;
         pin_q  <= 3'h1;
      end else if (ce_i) begin
         meta_q <= {cmp2_i, cmp1_i, fault_input_n_i};
         pin_q  <= meta_q;
      end
   end

   // -----------------------------------------------------------
   // time base
   // -----------------------------------------------------------
   wire logic [1:0] mode_sel = pwm_mode_control_q[3:2];
   wire logic [1:0] out_cfg  = pwm_mode_control_q[MODE_CFG_HI -: 2];
   wire logic       cfg_dir  = pwm_mode_control_q[MODE_DIR_BIT];
   wire logic pwm_on = (mode_sel == MODE_PWM);
   wire logic half   = pwm_on & (out_cfg == CFG_HALF);
   wire logic full   = pwm_on & out_cfg[0];
   wire logic single = pwm_on & (out_cfg == CFG_SINGLE);

   logic [3:0] pre_max;
   logic [3:0] pre_cnt_q;
   logic [1:0] q_q;
   logic [9:0] duty_q;

   always_comb begin
      case (prescale_q)
         2'h0:    pre_max = PRE_MAX_1;
         2'h1:    pre_max = PRE_MAX_4;
         default: pre_max = PRE_MAX_16;
      endcase
   end

   wire logic pre_tick   = (pre_cnt_q == pre_max);
   wire logic last_step  = (period_timer_q == period_limit_q)
                           & (q_q == 2'h3);
   wire logic period_end = pwm_on & pre_tick & last_step;
   wire logic [9:0] duty_new = {duty_high_byte_q,
                                pwm_mode_control_q[MODE_DUTY_HI -: 2]};

   // the time base sits reset while pwm is off, so enabling always
   // starts a clean period and never a partial waveform
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pre_cnt_q      <= 4'h0;
         q_q            <= 2'h0;
         period_timer_q <= 8'h0;
         duty_q         <= 10'h0;
      end else if (ce_i) begin
         if (!pwm_on) begin
            pre_cnt_q      <= 4'h0;
            q_q            <= 2'h0;
            period_timer_q <= 8'h0;
            duty_q         <= duty_new;
         end else if (pre_tick) begin
            pre_cnt_q <= 4'h0;
            q_q       <= q_q + 2'h1;
            if (period_end) begin
               period_timer_q <= 8'h0;
               duty_q         <= duty_new;
            end else if (q_q == 2'h3) begin
               period_timer_q <= period_timer_q + 8'h1;
            end
         end else begin
            pre_cnt_q <= pre_cnt_q + 4'h1;
         end
      end
   end

   // each fine step of the timer lasts one prescaled clock
   wire logic raw = ({period_timer_q, q_q} < duty_q);

   // -----------------------------------------------------------
   // period flag, set wins over a write-one clear
   // -----------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         period_match_flag_q <= 1'b0;
      end else if (ce_i) begin
         if (period_end) begin
            period_match_flag_q <= 1'b1;
         end else if (wr_stat && dat_i[STAT_FLAG_BIT]) begin
            period_match_flag_q <= 1'b0;
         end
      end
   end

   // -----------------------------------------------------------
   // full bridge direction
   // -----------------------------------------------------------
   logic dir_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dir_q <= 1'b0;
      end else if (ce_i) begin
         if (!pwm_on || period_end) dir_q <= cfg_dir;
      end
   end

   wire logic pend   = full & (cfg_dir != dir_q);
   // a and c swap during the last prescaled clock of the period
   wire logic ac_dir = (pend & last_step) ? cfg_dir : dir_q;

   // -----------------------------------------------------------
   // dead band for the half bridge pair
   // -----------------------------------------------------------
   wire logic [8:0] db_target = {deadband_control_q[6:0], 2'b00};
   logic [1:0] want;
   logic [8:0] db_cnt_q [2];
   logic [1:0] db_act;

   assign want = {~raw, raw};

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         db_cnt_q[0] <= 9'h0;
         db_cnt_q[1] <= 9'h0;
      end else if (ce_i) begin
         for (int i = 0; i < 2; i++) begin
            if (!want[i] || !half) begin
               db_cnt_q[i] <= 9'h0;
            end else if (db_cnt_q[i] != db_target) begin
               db_cnt_q[i] <= db_cnt_q[i] + 9'h1;
            end
         end
      end
   end

   // a pulse shorter than the delay ends before the count does
   assign db_act[0] = want[0] & (db_cnt_q[0] == db_target);
   assign db_act[1] = want[1] & (db_cnt_q[1] == db_target);

   // -----------------------------------------------------------
   // active levels per mode, index 0..3 = a..d
   // -----------------------------------------------------------
   logic [3:0] act;
   logic [3:0] oe_mode;

   always_comb begin
      act     = 4'h0;
      oe_mode = 4'h0;
      if (half) begin
         act     = {2'b00, db_act};
         oe_mode = OE_HALF;
      end else if (full) begin
         // no dead band in the full bridge
         act[0]  = ~ac_dir;
         act[2]  = ac_dir;
         act[3]  = raw & ~dir_q & ~pend;
         act[1]  = raw & dir_q & ~pend;
         oe_mode = OE_FULL;
      end else if (single) begin
         act[0]  = raw;
         oe_mode = OE_SINGLE;
      end
   end

   wire logic pol_ac = pwm_mode_control_q[MODE_POL_AC];
   wire logic pol_bd = pwm_mode_control_q[MODE_POL_BD];
   wire logic [3:0] pol  = {pol_bd, pol_ac, pol_bd, pol_ac};
   wire logic [3:0] level = act ^ pol;

   // -----------------------------------------------------------
   // auto shutdown
   // -----------------------------------------------------------
   wire logic [2:0] sd_src = shutdown_control_q[SD_SRC_HI -: 3];
   wire logic       sd_cond = (sd_src[0] & pin_q[1])
                            | (sd_src[1] & pin_q[2])
                            | (sd_src[2] & ~pin_q[0]);
   wire logic fw_set = wr_sd & dat_i[SD_STATUS_BIT];
   wire logic fw_clr = wr_sd & ~dat_i[SD_STATUS_BIT];
   logic hold_q;

   // status cannot be cleared while the level cause persists
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         shutdown_status_q <= 1'b0;
         hold_q            <= 1'b0;
      end else if (ce_i) begin
         if (sd_cond || fw_set) begin
            shutdown_status_q <= 1'b1;
         end else if (fw_clr) begin
            shutdown_status_q <= 1'b0;
         end
         if (shutdown_status_q || sd_cond) begin
            hold_q <= 1'b1;
         end else if (period_end) begin
            hold_q <= 1'b0;
         end
      end
   end

   // the synced cause forces pins the same cycle, without waiting
   // for the status register or a period edge
   wire logic sd_now = sd_cond | shutdown_status_q | hold_q;
   wire logic [1:0] pss_ac = shutdown_control_q[3:2];
   wire logic [1:0] pss_bd = shutdown_control_q[1:0];
   wire logic [3:0] sd_lvl = {pss_bd[0], pss_ac[0],
                              pss_bd[0], pss_ac[0]};
   wire logic [3:0] sd_oe  = ~{pss_bd[1], pss_ac[1],
                               pss_bd[1], pss_ac[1]};

   // one assignment keeps the carrier a single-driver variable
   assign pins_o = {(sd_now ? sd_lvl : level) & oe_mode,
                    sd_now ? (oe_mode & sd_oe) : oe_mode};

   // -----------------------------------------------------------
   // checks
   // -----------------------------------------------------------
   logic [15:0] len_q;
   logic [15:0] hi_q;
   logic        stable_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         len_q    <= 16'h0;
         hi_q     <= 16'h0;
         stable_q <= 1'b0;
      end else if (ce_i) begin
         len_q    <= period_end ? 16'h1 : len_q + 16'h1;
         hi_q     <= period_end ? {15'h0, raw} : hi_q + {15'h0, raw};
         stable_q <= wr ? 1'b0 : (period_end | stable_q) & pwm_on;
      end
   end

   // widened before the sum: a period limit of 255 overflows 10 bits
   wire logic [15:0] pre_fac = {12'h0, pre_max} + 16'h1;
   wire logic [15:0] exp_len = ({6'h0, period_limit_q, 2'b00} + 16'h4)
                               * pre_fac;
   wire logic [15:0] exp_hi  = {6'h0, duty_q} * pre_fac;

   AST_PERIOD_LEN: assert property (
      @(posedge clk_i) disable iff (rst_i)
      period_end && ce_i && stable_q |-> len_q == exp_len)
      else $error("pwm period length wrong");
   AST_DUTY_LEN: assert property (
      @(posedge clk_i) disable iff (rst_i)
      ce_i && stable_q && !raw && $past(raw) && !period_end
      |-> hi_q == exp_hi)
      else $error("pulse width wrong");
   AST_DB_DELAY: assert property (
      @(posedge clk_i) disable iff (rst_i)
      ce_i && half && deadband_control_q[6:0] != 7'h0
      && want[0] && !$past(want[0]) |-> !db_act[0][*4])
      else $error("dead band not applied");
   AST_HALF_COMP: assert property (
      @(posedge clk_i) disable iff (rst_i)
      half |-> !(act[0] && act[1]))
      else $error("half bridge outputs overlap");
   AST_FWD: assert property (
      @(posedge clk_i) disable iff (rst_i)
      full && !dir_q && !pend |-> act[0] && !act[1] && !act[2])
      else $error("forward pattern wrong");
   AST_REV: assert property (
      @(posedge clk_i) disable iff (rst_i)
      full && dir_q && !pend |-> act[2] && !act[0] && !act[3])
      else $error("reverse pattern wrong");
   AST_DIR_SWAP: assert property (
      @(posedge clk_i) disable iff (rst_i)
      pend |-> !act[1] && !act[3])
      else $error("modulated outputs active during turn");
   AST_DIR_NEXT: assert property (
      @(posedge clk_i) disable iff (rst_i)
      ce_i && period_end && pend |=> dir_q == $past(cfg_dir))
      else $error("direction not applied at period");
   AST_SD_SET: assert property (
      @(posedge clk_i) disable iff (rst_i)
      ce_i && sd_cond |=> shutdown_status_q && pins_o.oe == (oe_mode
      & sd_oe))
      else $error("shutdown not latched");
   AST_SD_PIN: assert property (
      @(posedge clk_i) disable iff (rst_i)
      sd_cond && oe_mode[0] && !pss_ac[1]
      |-> pins_o.oe[0] && pins_o.drive[0] == pss_ac[0])
      else $error("shutdown level on pin a wrong");
   AST_FLAG: assert property (
      @(posedge clk_i) disable iff (rst_i)
      ce_i && period_end |=> period_match_flag_q)
      else $error("period flag not set");

   COV_DIR: cover property (@(posedge clk_i) pend ##1 !pend);
   COV_SD: cover property (@(posedge clk_i) sd_cond ##1 !hold_q);
   COV_DB: cover property (@(posedge clk_i) half && $rose(db_act[1]));

endmodule // bridge_pwm
`default_nettype wire

/* File: test/bridge_load.sv */
// model of the external bridge switch drivers with pull-down resistors
`default_nettype none
module bridge_load (
   input  wire logic                     clk_i,
   input  wire bridge_pwm_pkg::pins_type pins_i,
   output logic [3:0]                    level_o,
   output int                            shoot_o
);
   import bridge_pwm_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   // a released pin falls to the pull-down, so float reads low
   assign level_o = pins_i.drive & pins_i.oe;
   initial shoot_o = 0;
   // upper and lower switch of leg a/b on together shorts the supply
   always @(posedge clk_i) begin
      if (&pins_i.oe[1:0] && &level_o[1:0])
         shoot_o <= shoot_o + 1;
   end
endmodule // bridge_load
`default_nettype wire

/* File: test/tb_top.sv */
// self-checking bench of the bridge pwm stage
`default_nettype none
module tb_top;
   import bridge_pwm_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc, stb, we, ack, flt_n, cmp1, cmp2;
   logic [7:0]  adr;
   logic [31:0] dat_w, dat_r, rd;
   pins_type    pins;
   logic [3:0]  lvl;
   int          shoot, errors, checks_done, cycles, rises, s;
   int          hi[4];
   // mode byte, then high clocks of a..d over two periods
   int mr[7][5] = '{'{8'h0c, 16, 0, 0, 0}, '{8'h4c, 32, 0, 0, 16},
      '{8'h8c, 16, 16, 0, 0}, '{8'hcc, 0, 16, 32, 0},
      '{8'h4f, 0, 32, 32, 16}, '{8'h8d, 16, 16, 0, 0},
      '{8'h48, 0, 0, 0, 0}};
   // shutdown byte, source (0 fw, 1 fault, 2 cmp1, 3 cmp2), oe, level
   int sr[5][4] = '{'{8'h46, 1, 4'h5, 4'h5}, '{8'h11, 2, 4'hf, 4'ha},
      '{8'h3b, 3, 4'h0, 4'h0}, '{8'h5c, 2, 4'ha, 4'h0},
      '{8'h05, 0, 4'hf, 4'hf}};
   always #2.5 clk_i = ~clk_i;
   bridge_pwm dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
      .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'h1),
      .dat_i(dat_w), .dat_o(dat_r), .ack_o(ack),
      .fault_input_n_i(flt_n), .cmp1_i(cmp1), .cmp2_i(cmp2),
      .pins_o(pins));
   bridge_load load (.clk_i(clk_i), .pins_i(pins), .level_o(lvl),
      .shoot_o(shoot));
   // ----------------------------------------------------------
   // bus, compare and measure tasks
   // ----------------------------------------------------------
   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat_w <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 20);
      rd = dat_r;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (n >= 20)
         errors++;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, g);
      checks_done++;
      if (g !== e) begin
         errors++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chk_cnt(input string nm, input int e, g);
      checks_done++;
      if (g != e) begin
         errors++;
         $display("BAD %s expected %0d seen %0d", nm, e, g);
      end
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   // counts high clocks per pin and rising edges of pin a
   task automatic measure(input int n);
      logic p;
      hi = '{default: 0};
      rises = 0;
      settle(1);
      p = lvl[0];
      repeat (n) begin
         settle(1);
         for (int i = 0; i < 4; i++)
            hi[i] += lvl[i];
         rises += int'(lvl[0] && !p);
         p = lvl[0];
      end
   endtask
   task automatic check4(input int a, b, c, d);
      chk_cnt("high a", a, hi[0]);
      chk_cnt("high b", b, hi[1]);
      chk_cnt("high c", c, hi[2]);
      chk_cnt("high d", d, hi[3]);
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         errors++;
         summarize();
      end
   end
   // ----------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------
   initial begin
      {cyc, stb, we, adr, dat_w, cmp1, cmp2} = '0;
      flt_n = 1'b1;
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      for (int i = 0; i < 8; i++) begin
         wb(1'b0, 8'(i * 4), 32'h0);
         chk("reset value", (i == 0) ? 32'hff : 32'h0, rd);
      end
      wb(1'b1, 8'h1c, 32'haa);
      wb(1'b0, 8'h1c, 32'h0);
      chk("unmapped", 32'h0, rd);
      $display("done registers");
      wb(1'b1, OFS_PERIOD, 32'h3);
      wb(1'b1, OFS_DUTY, 32'h2);
      foreach (mr[i]) begin
         wb(1'b1, OFS_MODE, 32'(mr[i][0]));
         settle(40);
         measure(32);
         check4(mr[i][1],mr[i][2],mr[i][3],mr[i][4]);
      end
      $display("done modes");
      wb(1'b1, OFS_MODE, 32'h8c);
      wb(1'b1, OFS_DEADBAND, 32'h1);
      settle(40);
      s = shoot;
      measure(32);
      check4(8, 8, 0, 0);
      chk_cnt("overlap", s, shoot);
      wb(1'b1, OFS_DEADBAND, 32'h3);
      settle(40);
      measure(32);
      check4(0, 0, 0, 0);
      wb(1'b1, OFS_MODE, 32'h4c);
      settle(40);
      measure(32);
      check4(32, 0, 0, 16);
      wb(1'b1, OFS_DEADBAND, 32'h0);
      $display("done dead band");
      s = 0;
      while (lvl[3] !== 1'b1 && s < 40) begin
         settle(1);
         s++;
      end
      wb(1'b1, OFS_MODE, 32'hcc);
      settle(1);
      chk("d forced off", 32'h0, lvl[3]);
      chk("a kept", 32'h1, lvl[0]);
      s = 0;
      while (lvl[2] !== 1'b1 && s < 40) begin
         settle(1);
         s++;
      end
      chk("a at swap", 32'h0, lvl[0]);
      chk("b at swap", 32'h0, lvl[1]);
      settle(1);
      chk("b resumes", 32'h1, lvl[1]);
      $display("done direction");
      wb(1'b1, OFS_PERIOD, 32'h1);
      wb(1'b1, OFS_DUTY, 32'h1);
      wb(1'b1, OFS_MODE, 32'h0c);
      for (int p = 0; p < 3; p++) begin
         if (p == 1)
            wb(1'b1, OFS_PRESCALE, 32'h1);
         if (p == 2) begin
            wb(1'b1, OFS_PRESCALE, 32'h0);
            wb(1'b1, OFS_DUTY, 32'h0);
            wb(1'b1, OFS_MODE, 32'h2c);
         end
         settle(80);
         measure(64);
         chk_cnt("periods", (p == 1) ? 2 : 8, rises);
         chk_cnt("width", (p == 2) ? 16 : 32, hi[0]);
      end
      $display("done timing");
      wb(1'b1, OFS_MODE, 32'h0);
      wb(1'b1, OFS_PERIOD, 32'h3);
      wb(1'b1, OFS_STATUS, 32'h1);
      wb(1'b1, OFS_MODE, 32'h0c);
      wb(1'b0, OFS_STATUS, 32'h0);
      chk("flag early", 32'h0, rd & 32'h1);
      settle(20);
      wb(1'b0, OFS_STATUS, 32'h0);
      chk("flag", 32'h1, rd & 32'h1);
      $display("done flag");
      // a long period keeps the restart edge away from the clear write
      wb(1'b1, OFS_PERIOD, 32'h3f);
      wb(1'b1, OFS_MODE, 32'h4c);
      foreach (sr[i]) begin
         s = sr[i][0] | ((sr[i][1] == 0) ? 8'h80 : 0);
         wb(1'b1, OFS_SHUTDOWN, 32'(s));
         flt_n <= (sr[i][1] != 1);
         cmp1 <= (sr[i][1] == 2);
         cmp2 <= (sr[i][1] == 3);
         settle(3);
         chk("oe down", 32'(sr[i][2]), pins.oe);
         chk("level down", 32'(sr[i][3]), lvl);
         wb(1'b1, OFS_SHUTDOWN, 32'(sr[i][0]));
         wb(1'b0, OFS_SHUTDOWN, 32'h0);
         s = (sr[i][1] == 0) ? sr[i][0] : (sr[i][0] | 8'h80);
         chk("status", 32'(s), rd);
         {flt_n, cmp1, cmp2} <= 3'h4;
         settle(4);
         wb(1'b1, OFS_SHUTDOWN, 32'(sr[i][0]));
         settle(1);
         chk("held", 32'(sr[i][2]), pins.oe);
         settle(300);
         wb(1'b0, OFS_SHUTDOWN, 32'h0);
         chk("cleared", 32'(sr[i][0]), rd);
         chk("resumed", 32'hf, pins.oe);
      end
      $display("done shutdown");
      summarize();
   end
endmodule // tb_top
`default_nettype wire
